// File: design/dout_fs_regs.svh
// register offsets, field positions, reset values and timing counts of the fail-safe output block
`ifndef DOUT_FS_REGS_SVH
`define DOUT_FS_REGS_SVH

// ==========================================================================
// register byte offsets
`define OFS_OUT_IMAGE     8'h00
`define OFS_OUT_POINT     8'h04
`define OFS_DRIVE         8'h08
`define OFS_FS_KIND       8'h0C
`define OFS_FS_DELAY      8'h10
`define OFS_FS_IMAGE      8'h14
`define OFS_FS_COMMIT     8'h18
`define OFS_STATUS        8'h1C

// ==========================================================================
// field positions
`define PT_SEL_MSB        2
`define PT_VAL_BIT        8
`define COMMIT_BIT        0
`define ST_ACTIVE_BIT     0
`define ST_KIND_LSB       8
`define ST_DELAY_LSB      16
`define ST_IMAGE_LSB      24

// ==========================================================================
// fail-safe kind codes
`define KIND_OFF          8'h01
`define KIND_IMAGE        8'h02
`define KIND_LAST         8'h03

// ==========================================================================
// reset values
`define RST_IMAGE         8'h00
`define RST_KIND          8'h01
`define RST_DELAY         8'h00

// ==========================================================================
// timing: one delay unit is a tenth of a second
`define TENTH_NS          100_000_000
`define MCLK_PERIOD_NS    100
`define TENTH_CYCLES      (`TENTH_NS / `MCLK_PERIOD_NS)
`define LOSS_TENTHS       10

`endif

// File: design/dout_fs_pkg.sv
// types shared by the fail-safe output block
package dout_fs_pkg;

    // ==========================================================================
    // output image, one bit per point
    typedef logic [7:0] image_t;

    // ==========================================================================
    // output state machine, one-hot
    typedef enum logic [1:0]
    {
        ST_RUN  = 2'b01,
        ST_SAFE = 2'b10
    } fs_state_t;

endpackage

// File: design/silence_timer.sv
// host silence timer counting tenths of a second since the last access
`timescale 1ns/1ps
`include "dout_fs_regs.svh"

module silence_timer #(
    parameter int TICK_CYCLES = `TENTH_CYCLES,
    parameter int CW          = 16
) (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst,
    // control
    input  wire logic          restart,
    input  wire logic [CW-1:0] limit,
    // status
    output logic               expired_q,
    output logic [CW-1:0]      tenths_q
);

    localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    logic [PW-1:0] cyc_q;

    // ==========================================================================
    // prescaler and tenths count, restarted by every host access to a mapped register
    always_ff @(posedge mclk)
    begin
        if (rst || restart)
        begin
            cyc_q    <= '0;
            tenths_q <= '0;
        end
        else if (cyc_q == PW'(TICK_CYCLES - 1))
        begin
            cyc_q <= '0;
            // saturate so a long silence never wraps back to zero
            if (tenths_q != {CW{1'b1}})
                tenths_q <= tenths_q + CW'(1);
        end
        else
            cyc_q <= cyc_q + PW'(1);
    end

    // ==========================================================================
    // expiry flag, cleared the edge after an access
    always_ff @(posedge mclk)
    begin
        if (rst)
            expired_q <= 1'b0;
        else
            expired_q <= !restart && (tenths_q >= limit);
    end

    // ==========================================================================
    // checks
    property p_restart_clears;
        @(posedge mclk) disable iff (rst)
        restart |=> (tenths_q == '0) && !expired_q;
    endproperty
    a_restart_clears: assert property (p_restart_clears)
        else $error("timer not cleared by host access");

    property p_expire_cause;
        @(posedge mclk) disable iff (rst)
        $rose(expired_q) |-> ($past(tenths_q) >= $past(limit)) && !$past(restart);
    endproperty
    a_expire_cause: assert property (p_expire_cause)
        else $error("expiry before delay elapsed");

endmodule // silence_timer

// File: design/dout_failsafe.sv
// eight-point digital output with host-loss fail-safe and apb register access
`timescale 1ns/1ps
`include "dout_fs_regs.svh"

// Behaviour
// - a byte image write drives points 0-7, one bit each; all ones on, zero off.
// - loss of host communication switches outputs into the fail-safe state.
// - fail-safe kind 1 turns all off, 2 applies stored image, 3 holds last state.
// - the stored fail-safe image is applied only when the kind equals 2.
// - in image fail-safe each point follows its image bit, for points 0-7.
// - fail-safe waits the committed delay in tenths of a second; 0 no wait.
// - staged kind, delay and image take effect only when commit is written.
// - commit clears itself right after the transfer; writing zero does nothing.
module dout_failsafe #(
    parameter int TICK_CYCLES = `TENTH_CYCLES,
    parameter int LOSS_TENTHS = `LOSS_TENTHS
) (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // output points
    output dout_fs_pkg::image_t        point_drive,
    output logic                       failsafe_active
);
    import dout_fs_pkg::*;

    fs_state_t   state_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;
    image_t      drive_q;
    logic        safe_q;
    image_t      out_image_q;
    logic [7:0]  kind_s_q;
    logic [7:0]  delay_s_q;
    image_t      image_s_q;
    logic [7:0]  kind_c_q;
    logic [7:0]  delay_c_q;
    image_t      image_c_q;
    logic        commit_q;
    logic        expired;
    logic        access_ph;
    logic        xfer;
    logic        restart;
    logic        wr_en;
    logic        enter;

    // ==========================================================================
    // helpers
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == `OFS_OUT_IMAGE) || (a == `OFS_OUT_POINT) || (a == `OFS_DRIVE)
            || (a == `OFS_FS_KIND) || (a == `OFS_FS_DELAY) || (a == `OFS_FS_IMAGE)
            || (a == `OFS_FS_COMMIT) || (a == `OFS_STATUS);
    endfunction

    // unknown kinds fall back to all off, the safest reading
    function automatic image_t apply_kind(input logic [7:0] kind, input image_t img, input image_t last);
        return (kind == `KIND_IMAGE) ? img : ((kind == `KIND_LAST) ? last : '0);
    endfunction

    // ==========================================================================
    // bus decode: access phase takes two cycles, pready registered
    assign access_ph = psel && penable && !pready_q;
    assign xfer      = psel && penable && pready_q;
    assign wr_en     = xfer && pwrite && is_mapped(paddr);
    assign restart   = xfer && is_mapped(paddr);
    assign enter     = (state_q == ST_RUN) && expired && !restart;

    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign point_drive     = drive_q;
    assign failsafe_active = safe_q;

    // read data selection
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `OFS_OUT_IMAGE: rd_mux = {24'h00_0000, out_image_q};
            `OFS_DRIVE:     rd_mux = {24'h00_0000, drive_q};
            `OFS_FS_KIND:   rd_mux = {24'h00_0000, kind_s_q};
            `OFS_FS_DELAY:  rd_mux = {24'h00_0000, delay_s_q};
            `OFS_FS_IMAGE:  rd_mux = {24'h00_0000, image_s_q};
            `OFS_FS_COMMIT: rd_mux = {31'h000_0000, commit_q};
            `OFS_STATUS:    rd_mux = {image_c_q, delay_c_q, kind_c_q, 7'h00, safe_q};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // apb answer, error on unmapped addresses
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= access_ph;
            pslverr_q <= access_ph && !is_mapped(paddr);
            prdata_q  <= (access_ph && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ==========================================================================
    // host output image, byte or single point
    always_ff @(posedge mclk)
    begin
        if (rst)
            out_image_q <= `RST_IMAGE;
        else if (wr_en && paddr == `OFS_OUT_IMAGE)
            out_image_q <= pwdata[7:0];
        else if (wr_en && paddr == `OFS_OUT_POINT)
            out_image_q[pwdata[`PT_SEL_MSB:0]] <= pwdata[`PT_VAL_BIT];
    end

    // staged fail-safe settings, no effect until committed
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            kind_s_q  <= `RST_KIND;
            delay_s_q <= `RST_DELAY;
            image_s_q <= `RST_IMAGE;
        end
        else if (wr_en)
        begin
            if (paddr == `OFS_FS_KIND)
                kind_s_q <= pwdata[7:0];
            if (paddr == `OFS_FS_DELAY)
                delay_s_q <= pwdata[7:0];
            if (paddr == `OFS_FS_IMAGE)
                image_s_q <= pwdata[7:0];
        end
    end

    // commit flag: set by writing one, cleared after one transfer cycle
    always_ff @(posedge mclk)
    begin
        if (rst)
            commit_q <= 1'b0;
        else
            commit_q <= wr_en && paddr == `OFS_FS_COMMIT && pwdata[`COMMIT_BIT];
    end

    // committed settings, the only ones the fail-safe logic reads
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            kind_c_q  <= `RST_KIND;
            delay_c_q <= `RST_DELAY;
            image_c_q <= `RST_IMAGE;
        end
        else if (commit_q)
        begin
            kind_c_q  <= kind_s_q;
            delay_c_q <= delay_s_q;
            image_c_q <= image_s_q;
        end
    end

    // ==========================================================================
    // silence timer: loss detection plus committed delay
    silence_timer #(
        .TICK_CYCLES (TICK_CYCLES),
        .CW          (16)
    ) u_timer (
        .mclk      (mclk),
        .rst       (rst),
        .restart   (restart),
        .limit     (16'(LOSS_TENTHS) + {8'h00, delay_c_q}),
        .expired_q (expired),
        .tenths_q  ()
    );

    // ==========================================================================
    // output state machine
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_q <= ST_RUN;
            safe_q  <= 1'b0;
            drive_q <= `RST_IMAGE;
        end
        else
        begin
            unique case (state_q)
                ST_RUN:
                begin
                    if (enter)
                    begin
                        state_q <= ST_SAFE;
                        safe_q  <= 1'b1;
                        drive_q <= apply_kind(kind_c_q, image_c_q, drive_q);
                    end
                    else
                        drive_q <= out_image_q;
                end
                ST_SAFE:
                begin
                    // outputs frozen until the host speaks again
                    if (restart)
                    begin
                        state_q <= ST_RUN;
                        safe_q  <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ==========================================================================
    // checks
    sequence s_enter;
        (state_q == ST_RUN) && expired && !restart;
    endsequence

    property p_image_follow;
        @(posedge mclk) disable iff (rst)
        (wr_en && paddr == `OFS_OUT_IMAGE && state_q == ST_RUN) |-> ##2 (drive_q == $past(pwdata[7:0], 2));
    endproperty
    a_image_follow: assert property (p_image_follow)
        else $error("outputs do not follow byte image");

    property p_enter_safe;
        @(posedge mclk) disable iff (rst)
        s_enter |=> (state_q == ST_SAFE) && safe_q;
    endproperty
    a_enter_safe: assert property (p_enter_safe)
        else $error("fail-safe not entered on loss");

    property p_hold_safe;
        @(posedge mclk) disable iff (rst)
        (state_q == ST_SAFE && !restart) |=> $stable(drive_q) && safe_q;
    endproperty
    a_hold_safe: assert property (p_hold_safe)
        else $error("outputs moved while in fail-safe");

    property p_kind_off;
        @(posedge mclk) disable iff (rst)
        (s_enter and (kind_c_q == `KIND_OFF)) |=> (drive_q == 8'h00);
    endproperty
    a_kind_off: assert property (p_kind_off)
        else $error("kind 1 did not turn all off");

    property p_kind_last;
        @(posedge mclk) disable iff (rst)
        (s_enter and (kind_c_q == `KIND_LAST)) |=> (drive_q == $past(drive_q));
    endproperty
    a_kind_last: assert property (p_kind_last)
        else $error("kind 3 did not hold last state");

    property p_kind_image;
        @(posedge mclk) disable iff (rst)
        s_enter |=> ((drive_q == $past(image_c_q)) || ($past(kind_c_q) != `KIND_IMAGE));
    endproperty
    a_kind_image: assert property (p_kind_image)
        else $error("image fail-safe not applied");

    property p_commit_only;
        @(posedge mclk) disable iff (rst)
        ($changed(kind_c_q) || $changed(delay_c_q) || $changed(image_c_q)) |-> $past(commit_q);
    endproperty
    a_commit_only: assert property (p_commit_only)
        else $error("settings changed without commit");

    property p_commit_clear;
        @(posedge mclk) disable iff (rst)
        (commit_q && !(wr_en && paddr == `OFS_FS_COMMIT)) |=> !commit_q;
    endproperty
    a_commit_clear: assert property (p_commit_clear)
        else $error("commit did not clear itself");

    property p_access_leave;
        @(posedge mclk) disable iff (rst)
        (state_q == ST_SAFE && restart) |=> (state_q == ST_RUN) ##1 (drive_q == $past(out_image_q));
    endproperty
    a_access_leave: assert property (p_access_leave)
        else $error("host access did not end fail-safe");

endmodule // dout_failsafe

// File: verif/apb_host.sv
// host model: apb master that writes outputs and stages fail-safe settings
`timescale 1ns/1ps
`include "dout_fs_regs.svh"

module apb_host (
    // clock
    input  wire logic        mclk,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // ==========================================================================
    // bus idle at time zero
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // ==========================================================================
    // one transfer; request held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic er);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        // no fixed latency assumed; only the bench timeout ends a hang
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // stage kind, delay and image; caller commits afterwards
    task automatic stage(input logic [7:0] k, input logic [7:0] dl, input logic [7:0] im);
        logic [31:0] rd;
        logic        er;
        xfer(1'b1, `OFS_FS_KIND, {24'h00_0000, k}, rd, er);
        xfer(1'b1, `OFS_FS_DELAY, {24'h00_0000, dl}, rd, er);
        xfer(1'b1, `OFS_FS_IMAGE, {24'h00_0000, im}, rd, er);
    endtask
endmodule // apb_host

// File: verif/tb.sv
// self-checking bench of the fail-safe output block against a host model
`timescale 1ns/1ps
`include "dout_fs_regs.svh"

module tb;
    import dout_fs_pkg::*;
    localparam int TICK  = 10;
    localparam int LOSS  = 2;
    localparam int LIMIT = 20000;

    logic        mclk, rst, psel, penable, pwrite, pready, pslverr, er, failsafe_active;
    logic [7:0]  paddr, m_img, c_kind, c_dly, c_img, dl, s_img;
    logic [31:0] pwdata, prdata, rd;
    image_t      point_drive;
    int          n_errors, n_checks, cyc, seed, n, thr;
    logic [23:0] stq[$];

    // ==========================================================================
    // design and host model
    dout_failsafe #(.TICK_CYCLES(TICK), .LOSS_TENTHS(LOSS)) i_dut (.mclk(mclk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .point_drive(point_drive), .failsafe_active(failsafe_active));
    apb_host i_host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // clock, 100 ns period
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // hang guard; far above the longest silence of 257 tenths
    always @(posedge mclk)
    begin
        cyc = cyc + 1;
        if (cyc == LIMIT)
        begin
            n_errors = n_errors + 1;
            final_report();
        end
    end

    // ==========================================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_errors = n_errors + 1;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, rd, er);
    endtask

    task automatic rdr(input logic [7:0] a);
        i_host.xfer(1'b0, a, 32'h0000_0000, rd, er);
    endtask

    // staging model: only the newest staged set is adopted at commit
    task automatic stg(input logic [7:0] k, input logic [7:0] d, input logic [7:0] im);
        i_host.stage(k, d, im);
        stq.push_back({k, d, im});
    endtask

    task automatic commit();
        logic [23:0] s;
        wr(`OFS_FS_COMMIT, 32'h0000_0001);
        s = stq.pop_back();
        stq.delete();
        {c_kind, c_dly, c_img} = s;
    endtask

    function automatic logic [7:0] rnd8();
        logic [31:0] r;
        r = $random(seed);
        return r[7:0];
    endfunction

    // committed settings as the status word shows them
    function automatic logic [31:0] status(input logic act);
        return {c_img, c_dly, c_kind, 7'h00, act};
    endfunction

    // outputs in fail-safe; unknown kinds fall back to all off
    function automatic logic [7:0] fs_out(input logic [7:0] k, input logic [7:0] im, input logic [7:0] last);
        return (k == 8'h02) ? im : (k == 8'h03) ? last : 8'h00;
    endfunction

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ==========================================================================
    // main sequence
    initial
    begin
        seed = 32'hfe0c;
        n_errors = 0;
        n_checks = 0;
        cyc = 0;
        rst = 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        m_img = 8'h00;
        c_kind = 8'h01;
        c_dly = 8'h00;
        c_img = 8'h00;
        rdr(`OFS_STATUS);
        chk(rd, status(1'b0));
        chk({24'h00_0000, point_drive}, 32'h0000_0000);
        // byte images: all on, all off, then random
        for (int i = 0; i < 6; i++)
        begin
            m_img = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd8();
            wr(`OFS_OUT_IMAGE, {24'h00_0000, m_img});
            rdr(`OFS_DRIVE);
            chk(rd, {24'h00_0000, m_img});
            chk({24'h00_0000, point_drive}, {24'h00_0000, m_img});
        end
        // single points 0-7
        for (int i = 0; i < 8; i++)
        begin
            dl = rnd8();
            m_img[i] = dl[0];
            wr(`OFS_OUT_POINT, {23'h0_0000, dl[0], 5'h00, i[2:0]});
            rdr(`OFS_OUT_IMAGE);
            chk(rd, {24'h00_0000, m_img});
            chk({24'h00_0000, point_drive}, {24'h00_0000, m_img});
        end
        // unmapped word: refused, nothing stored
        wr(8'h20, 32'hffff_ffff);
        chk({31'h000_0000, er}, 32'h0000_0001);
        rdr(`OFS_OUT_IMAGE);
        chk(rd, {24'h00_0000, m_img});
        // staged settings stay unused until commit; writing zero does nothing
        s_img = rnd8();
        stg(8'h02, 8'h05, s_img);
        rdr(`OFS_STATUS);
        chk(rd, status(1'b0));
        wr(`OFS_FS_COMMIT, 32'h0000_0000);
        rdr(`OFS_STATUS);
        chk(rd, status(1'b0));
        commit();
        rdr(`OFS_FS_COMMIT);
        chk(rd, 32'h0000_0000);
        rdr(`OFS_STATUS);
        chk(rd, status(1'b0));
        // every kind with its own delay, 255 the longest
        for (int k = 1; k <= 4; k++)
        begin
            dl = (k == 1) ? 8'h00 : (k == 2) ? 8'h01 : (k == 3) ? 8'hff : 8'h03;
            m_img = rnd8();
            wr(`OFS_OUT_IMAGE, {24'h00_0000, m_img});
            s_img = rnd8();
            stg(k[7:0], dl, s_img);
            commit();
            // accesses closer than the loss time keep it from expiring
            if (k == 1)
                repeat (3)
                begin
                    repeat (15) @(posedge mclk);
                    rdr(`OFS_STATUS);
                    chk(rd, status(1'b0));
                end
            thr = (LOSS + dl) * TICK;
            n = 0;
            while (failsafe_active !== 1'b1 && n < thr + 20)
            begin
                @(posedge mclk);
                n = n + 1;
            end
            chk({31'h000_0000, (n >= thr - 3 && n <= thr + 6)}, 32'h0000_0001);
            repeat (4) @(posedge mclk);
            chk({24'h00_0000, point_drive}, {24'h00_0000, fs_out(c_kind, c_img, m_img)});
            // a host access ends fail-safe and restores the host image
            rdr(`OFS_DRIVE);
            chk(rd, {24'h00_0000, fs_out(c_kind, c_img, m_img)});
            repeat (3) @(posedge mclk);
            chk({31'h000_0000, failsafe_active}, 32'h0000_0000);
            chk({24'h00_0000, point_drive}, {24'h00_0000, m_img});
        end
        final_report();
    end
endmodule // tb
